// File: pkg/host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

// ---------------------------------------------------------------
// bus widths
// ---------------------------------------------------------------
`define HP_ADDR_W        11
`define HP_DATA_W        8

// ---------------------------------------------------------------
// pin synchroniser bundle: {cs, rw/wr/sdi, ds/rd/sclk, serial, style, addr, data}
// ---------------------------------------------------------------
`define HP_PIN_W         24
`define HP_PIN_RESET     24'he00000
`define HP_PIN_CS        23
`define HP_PIN_RW        22
`define HP_PIN_DS        21
`define HP_PIN_SER       20
`define HP_PIN_STYLE     19
`define HP_PIN_ADDR_HI   18
`define HP_PIN_ADDR_LO   8
`define HP_PIN_DATA_HI   7
`define HP_PIN_DATA_LO   0

// ---------------------------------------------------------------
// serial frame: 16 command bits msb first, then 8 data bits
// ---------------------------------------------------------------
`define HP_CMD_BITS      5'd16
`define HP_FRAME_BITS    5'd24
`define HP_CMD_RD_BIT    15
`define HP_CMD_ADDR_HI   10
`define HP_CMD_ADDR_LO   0

// ---------------------------------------------------------------
// parallel state codes (one-hot)
// ---------------------------------------------------------------
`define HP_ST_IDLE       3'h1
`define HP_ST_ACC        3'h2
`define HP_ST_WAIT       3'h4

`endif

// File: rtl/sync2.v
`timescale 1ns/10ps
// ---------------------------------------------------------------
// two-flop synchroniser for a bundle of asynchronous pins
// ---------------------------------------------------------------
module sync2 #(
  parameter             W         = 1,
  parameter [W-1:0]     RESET_VAL = {W{1'b0}}
) (
  // clock and reset
  input  wire           mclk_i,
  input  wire           reset_n_i,
  // pins in, synchronised out
  input  wire [W-1:0]   async_i,
  output wire [W-1:0]   sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// File: rtl/host_port.v
`timescale 1ns/10ps
`include "host_port_consts.vh"

module host_port #(
  parameter AW = `HP_ADDR_W,
  parameter DW = `HP_DATA_W
) (
  // clock and reset
  input  wire          mclk_i,
  input  wire          reset_n_i,
  // host pins
  input  wire          chip_select_n_i,
  input  wire          rw_wr_sdi_i,
  input  wire          data_strobe_n_i,
  input  wire          serial_port_select_i,
  input  wire          bus_style_select_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] data_i,
  output wire [DW-1:0] data_o,
  output wire [DW-1:0] data_oe_o,
  // internal register side
  output wire [AW-1:0] reg_addr_o,
  output wire [DW-1:0] reg_wdata_o,
  output wire          reg_wr_o,
  output wire          reg_rd_o,
  input  wire [DW-1:0] reg_rdata_i
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  wire [`HP_PIN_W-1:0] pins_s;

  sync2 #(
    .W         (`HP_PIN_W),
    .RESET_VAL (`HP_PIN_RESET)
  ) u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({chip_select_n_i, rw_wr_sdi_i, data_strobe_n_i, serial_port_select_i,
                 bus_style_select_i, addr_i, data_i}),
    .sync_o    (pins_s)
  );

  wire          cs_n_s   = pins_s[`HP_PIN_CS];
  wire          rw_s     = pins_s[`HP_PIN_RW];
  wire          ds_s     = pins_s[`HP_PIN_DS];
  wire          serial_s = pins_s[`HP_PIN_SER];
  wire          intel_s  = pins_s[`HP_PIN_STYLE];
  wire [AW-1:0] addr_s   = pins_s[`HP_PIN_ADDR_HI:`HP_PIN_ADDR_LO];
  wire [DW-1:0] data_s   = pins_s[`HP_PIN_DATA_HI:`HP_PIN_DATA_LO];

  // ---------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------
  // motorola: data strobe low qualifies, r/w high = read
  // intel: read strobe or write strobe low
  wire par_mode  = ~serial_s;
  wire strobe_on = intel_s ? (~ds_s | ~rw_s) : ~ds_s;
  wire is_read   = intel_s ? ~ds_s : rw_s;

  // ---------------------------------------------------------------
  // shared registers
  // ---------------------------------------------------------------
  reg [2:0]    state_reg;
  reg [2:0]    state_next;
  reg [AW-1:0] addr_reg;
  reg [DW-1:0] wdata_reg;
  reg [DW-1:0] pdata_reg;
  reg          read_reg;
  reg          wr_reg;
  reg          rd_reg;
  reg          rd_pend_reg;
  reg          sclk_q_reg;
  reg [4:0]    bit_cnt_reg;
  reg [15:0]   cmd_reg;
  reg          ser_rd_reg;
  reg [DW-1:0] sout_reg;
  reg          sdo_reg;

  wire sclk_rise = ds_s & ~sclk_q_reg;
  wire sclk_fall = ~ds_s & sclk_q_reg;
  wire ser_act   = serial_s & ~cs_n_s;

  // ---------------------------------------------------------------
  // parallel state machine
  // ---------------------------------------------------------------
  // next state: one access per chip-select low period
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `HP_ST_IDLE: begin
        if (par_mode && !cs_n_s && strobe_on)
          state_next = `HP_ST_ACC;
      end
      `HP_ST_ACC: begin
        if (!strobe_on || cs_n_s)
          state_next = `HP_ST_WAIT;
      end
      `HP_ST_WAIT: begin
        if (cs_n_s)
          state_next = `HP_ST_IDLE;
      end
      default: state_next = `HP_ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // transfers: parallel and serial share the register-side outputs
  // ---------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg   <= `HP_ST_IDLE;
      addr_reg    <= {AW{1'b0}};
      wdata_reg   <= {DW{1'b0}};
      pdata_reg   <= {DW{1'b0}};
      read_reg    <= 1'b0;
      wr_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      rd_pend_reg <= 1'b0;
      sclk_q_reg  <= 1'b1;
      bit_cnt_reg <= 5'h00;
      cmd_reg     <= 16'h0000;
      ser_rd_reg  <= 1'b0;
      sout_reg    <= {DW{1'b0}};
      sdo_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      wr_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      rd_pend_reg <= rd_reg;
      sclk_q_reg  <= ds_s;
      // parallel access start: latch address, launch a read
      if (state_reg == `HP_ST_IDLE && state_next == `HP_ST_ACC) begin
        addr_reg <= addr_s;
        read_reg <= is_read;
        rd_reg   <= is_read;
      end
      // parallel write: track bus while strobed, commit at release
      if (state_reg == `HP_ST_ACC && !read_reg) begin
        if (state_next == `HP_ST_WAIT)
          wr_reg <= 1'b1;
        else
          wdata_reg <= data_s;
      end
      // read data returns one cycle after the read pulse
      if (rd_pend_reg) begin
        if (serial_s)
          sout_reg <= reg_rdata_i;
        else
          pdata_reg <= reg_rdata_i;
      end
      // serial frame
      if (!ser_act) begin
        bit_cnt_reg <= 5'h00;
        ser_rd_reg  <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt_reg < `HP_FRAME_BITS) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg < `HP_CMD_BITS) begin
            cmd_reg <= {cmd_reg[14:0], rw_s};
            if (bit_cnt_reg == `HP_CMD_BITS - 5'h01) begin
              // address comes from the frame, parallel address pins unused
              addr_reg   <= {cmd_reg[`HP_CMD_ADDR_HI-1:0], rw_s};
              ser_rd_reg <= cmd_reg[`HP_CMD_RD_BIT-1];
              rd_reg     <= cmd_reg[`HP_CMD_RD_BIT-1];
            end
          end else if (!ser_rd_reg) begin
            wdata_reg <= {wdata_reg[DW-2:0], rw_s};
            if (bit_cnt_reg == `HP_FRAME_BITS - 5'h01)
              wr_reg <= 1'b1;
          end
        end
        // read data shifts out msb first on falling edges only
        if (sclk_fall && ser_rd_reg) begin
          sdo_reg  <= sout_reg[DW-1];
          sout_reg <= {sout_reg[DW-2:0], 1'b0};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  wire par_drive = par_mode & ~cs_n_s & read_reg & (state_reg == `HP_ST_ACC) & strobe_on;

  assign data_o      = serial_s ? {{(DW-1){1'b0}}, sdo_reg} : pdata_reg;
  assign data_oe_o   = serial_s ? {{(DW-1){1'b0}}, ser_act & ser_rd_reg} :
                                  {DW{par_drive}};
  assign reg_addr_o  = addr_reg;
  assign reg_wdata_o = wdata_reg;
  assign reg_wr_o    = wr_reg;
  assign reg_rd_o    = rd_reg;

endmodule

// File: test/host_port_assertions.sv
`timescale 1ns/10ps
// -----------------------------------------------
// port checker
// -----------------------------------------------
module host_port_chk (
  input wire       mclk_i,
  input wire       reset_n_i,
  input wire       chip_select_n_i,
  input wire       rw_wr_sdi_i,
  input wire       data_strobe_n_i,
  input wire       serial_port_select_i,
  input wire [7:0] data_o,
  input wire [7:0] data_oe_o,
  input wire       reg_wr_o,
  input wire       reg_rd_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // register side pulses
  chk_rd_wr_excl: assert property (!(reg_wr_o && reg_rd_o))
    else $error("read and write pulse together");
  chk_wr_single: assert property (reg_wr_o |=> !reg_wr_o [*4])
    else $error("write pulse repeated");
  chk_rd_single: assert property (reg_rd_o |=> !reg_rd_o [*4])
    else $error("read pulse repeated");
  chk_rd_selected: assert property (reg_rd_o |-> !$past(chip_select_n_i, 3))
    else $error("read without chip select");
  // bus drive
  chk_oe_selected: assert property (|data_oe_o |->
    !$past(chip_select_n_i, 2) || !$past(chip_select_n_i, 3))
    else $error("bus driven while deselected");
  chk_ser_oe_bit0: assert property (serial_port_select_i [*4] |->
    data_oe_o[7:1] == 7'h00)
    else $error("serial mode drives upper bits");
  chk_par_oe_dir: assert property (data_oe_o[7] |-> $past(rw_wr_sdi_i, 3))
    else $error("bus driven during write");
  chk_par_oe_strobe: assert property (data_oe_o[7] |->
    !$past(data_strobe_n_i, 2) || !$past(data_strobe_n_i, 3))
    else $error("bus driven without strobe");
  chk_sdo_on_fall: assert property (serial_port_select_i && data_oe_o[0] &&
    $past(data_oe_o[0]) && $changed(data_o[0]) |->
    !$past(data_strobe_n_i, 3) && $past(data_strobe_n_i, 4))
    else $error("serial out changed off falling clock");
  cover property (reg_wr_o && serial_port_select_i);
  cover property (reg_rd_o && !serial_port_select_i);
  cover property (data_oe_o[0] && serial_port_select_i);
endmodule
bind host_port host_port_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .chip_select_n_i(chip_select_n_i), .rw_wr_sdi_i(rw_wr_sdi_i),
  .data_strobe_n_i(data_strobe_n_i), .serial_port_select_i(serial_port_select_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o));

// File: test/host_model.sv
`timescale 1ns/10ps
// -----------------------------------------------
// host processor model
// -----------------------------------------------
module host_model (
  // clock and resolved bus
  input  wire        mclk_i,
  input  wire  [7:0] bus_i,
  // host pins
  output logic       cs_n_o  = 1'b1,
  output logic       rw_o    = 1'b1,
  output logic       ds_o    = 1'b1,
  output logic       ser_o   = 1'b0,
  output logic       style_o = 1'b0,
  output logic [10:0] addr_o = 11'h000,
  output logic [7:0] data_o  = 8'h00
);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one parallel access, select raised after strobe release
  task automatic par(input logic st, rd, input logic [10:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    ser_o <= 1'b0; style_o <= st; cs_n_o <= 1'b0;
    tick(3);
    addr_o <= a; data_o <= d;
    rw_o <= rd; ds_o <= st & !rd;
    tick(10); #1;
    q = bus_i;
    tick(1);
    rw_o <= 1'b1; ds_o <= 1'b1;
    tick(4);
    cs_n_o <= 1'b1;
    tick(4);
    data_o <= ~d; // released bus shows inverse
  endtask
  // serial frame of n bits, clock idles high
  task automatic spi(input logic [23:0] f, input int n, output logic [7:0] q);
    ser_o <= 1'b1; cs_n_o <= 1'b0; addr_o <= ~f[18:8];
    tick(4);
    for (int i = 0; i < n; i++) begin
      ds_o <= 1'b0; rw_o <= f[23-i];
      tick(8);
      q = {q[6:0], bus_i[0]};
      ds_o <= 1'b1;
      tick(8);
    end
    tick(4);
    cs_n_o <= 1'b1;
    tick(6);
  endtask
endmodule

// File: test/host_port_bench.sv
`timescale 1ns/10ps
module host_port_bench;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  wire         cs_n, rw, ds, ser, sty, wr, rd;
  wire  [10:0] addr, reg_addr;
  wire  [7:0]  hd, dout, oe, wdata, rdata, bus;
  int          n_fail = 0, checks = 0, n_wr = 0, n_rd = 0;
  logic [10:0] wa;
  logic [7:0]  wd;
  // clock, bus resolution, register stand-in
  always #5 mclk_i = ~mclk_i;
  assign bus = (oe & dout) | (~oe & hd);
  assign rdata = reg_addr[7:0] ^ 8'h5a;
  always @(posedge mclk_i) begin
    if (wr) begin n_wr++; wa = reg_addr; wd = wdata; end
    if (rd) n_rd++;
  end
  host_port dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
    .rw_wr_sdi_i(rw), .data_strobe_n_i(ds), .serial_port_select_i(ser),
    .bus_style_select_i(sty), .addr_i(addr), .data_i(bus), .data_o(dout),
    .data_oe_o(oe), .reg_addr_o(reg_addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata));
  host_model hm (.mclk_i(mclk_i), .bus_i(bus), .cs_n_o(cs_n), .rw_o(rw), .ds_o(ds),
    .ser_o(ser), .style_o(sty), .addr_o(addr), .data_o(hd));
  task automatic check(input string nm, input logic [23:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic par_write(input logic st, input logic [10:0] a, input logic [7:0] d);
    int c; logic [7:0] q;
    c = n_wr;
    hm.par(st, 1'b0, a, d, q);
    check("par wr count", c + 1, n_wr);
    check("par wr addr", a, wa);
    check("par wr data", d, wd);
  endtask
  task automatic par_read(input logic st, input logic [10:0] a);
    int c; logic [7:0] q;
    c = n_rd;
    hm.par(st, 1'b1, a, 8'h00, q);
    check("par rd count", c + 1, n_rd);
    check("par rd data", a[7:0] ^ 8'h5a, q);
  endtask
  task automatic spi_write(input logic [10:0] a, input logic [7:0] d);
    int c; logic [7:0] q;
    c = n_wr;
    hm.spi({1'b0, 4'h0, a, d}, 24, q);
    check("spi wr count", c + 1, n_wr);
    check("spi wr addr", a, wa);
    check("spi wr data", d, wd);
  endtask
  task automatic spi_read(input logic [10:0] a);
    int c; logic [7:0] q;
    c = n_rd;
    hm.spi({1'b1, 4'hf, a, 8'h00}, 24, q);
    check("spi rd count", c + 1, n_rd);
    check("spi rd data", a[7:0] ^ 8'h5a, q);
  endtask
  task automatic spi_abort(input logic [10:0] a);
    int c; logic [7:0] q;
    c = n_wr;
    hm.spi({1'b0, 4'h0, a, 8'hff}, 20, q);
    check("spi abort count", c, n_wr);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    hm.tick(4);
    par_write(1'b0, 11'h7ff, 8'ha5);
    par_write(1'b1, 11'h000, 8'h3c);
    par_read(1'b0, 11'h555);
    par_read(1'b1, 11'h2aa);
    spi_write(11'h4c3, 8'h96);
    spi_read(11'h7ff);
    spi_abort(11'h123);
    spi_write(11'h001, 8'h01);
    par_read(1'b0, 11'h0f0);
    report_and_stop;
  end
  // watchdog
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule
